// File: verilog/bsb_pkg.sv
// Constants and carrier types for the downstream bus configuration registers
package bsb_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_LAST_BUS = 8'h1a;
  localparam logic [7:0] IDX_LATENCY = 8'h1b;
  localparam logic [7:0] IDX_IO_BOTTOM = 8'h1c;
  localparam logic [7:0] IDX_IO_TOP = 8'h1d;
  localparam logic [7:0] IDX_EVENTS = 8'h1e;
  localparam int IDX_SHIFT = 2;

  localparam logic [7:0] LAST_BUS_RESET = 8'h00;
  localparam logic [7:0] LATENCY_RESET = 8'h00;
  localparam logic [3:0] IO_NIBBLE_RESET = 4'h0;
  localparam logic [3:0] IO_DECODE_32BIT = 4'h1;
  localparam logic [15:0] EVENTS_FIXED = 16'h0280;
  localparam logic [15:0] EVENTS_FLAG_MASK = 16'hf900;
  localparam logic [15:0] EVENTS_RESET = 16'h0280;

  localparam int EV_PARITY_DETECTED = 15;
  localparam int EV_SYSTEM_ERROR = 14;
  localparam int EV_MASTER_ABORT = 13;
  localparam int EV_TARGET_ABORT_RX = 12;
  localparam int EV_TARGET_ABORT_TX = 11;
  localparam int EV_DATA_PARITY = 8;

  localparam logic [11:0] IO_LOW_ZEROS = 12'h000;
  localparam logic [11:0] IO_LOW_ONES = 12'hfff;
  localparam logic [7:0] LATENCY_MAX = 8'hff;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic [7:0] bus;
  } bsb_cfg_req_type;

  typedef struct packed {
    logic type1_forward;
    logic type0_convert;
  } bsb_cfg_route_type;

  typedef struct packed {
    logic parity_detected;
    logic master_abort;
    logic target_abort_rx;
    logic target_abort_tx;
    logic bus_master;
  } bsb_events_type;

endpackage

// File: verilog/bsb_config_regs.sv
// Downstream bus configuration registers with forwarding and latency logic
//
// Added by the designer: the AHB-Lite interface to the registers.
module bsb_config_regs #(
  parameter int ADDR_WIDTH = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ADDR_WIDTH-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Bus numbers and window upper halves held elsewhere
  input wire logic [7:0] primary_bus_number,
  input wire logic [7:0] secondary_bus_number,
  input wire logic [15:0] io_base_upper,
  input wire logic [15:0] io_limit_upper,
  input wire logic parity_response_enable,
  // Type 1 configuration request from upstream
  input wire bsb_pkg::bsb_cfg_req_type cfg_req,
  output bsb_pkg::bsb_cfg_route_type cfg_route,
  // I/O address decode
  input wire logic [31:0] io_address,
  output logic io_window_hit,
  output logic [31:0] io_window_base,
  output logic [31:0] io_window_limit,
  // Downstream initiator
  input wire logic frame_start,
  input wire logic transfer_done,
  input wire logic other_master_request,
  output logic downstream_grant,
  output logic latency_terminate,
  // Downstream events and lines
  input wire bsb_pkg::bsb_events_type events,
  input wire logic downstream_system_error,
  input wire logic downstream_parity_error,
  output logic downstream_system_error_out,
  output logic downstream_system_error_oe
);

  initial begin
    if (ADDR_WIDTH < 8 + bsb_pkg::IDX_SHIFT) begin
      $error("bsb_config_regs: ADDR_WIDTH too small");
    end
  end

  // Register state
  logic [7:0] last_downstream_bus_number;
  logic [7:0] downstream_latency_limit;
  logic [3:0] io_bottom_nibble;
  logic [3:0] io_top_nibble;
  logic [15:0] event_flags;
  logic [7:0] latency_count;
  logic latency_active;
  logic wr_pending;
  logic [7:0] wr_index;
  logic [7:0] rd_index;
  logic rd_pending;

  // Bus decode
  wire addr_phase = hsel && hready &&
    (htrans == bsb_pkg::HTRANS_NONSEQ || htrans == bsb_pkg::HTRANS_SEQ);
  wire addr_aligned = haddr[bsb_pkg::IDX_SHIFT-1:0] == '0;
  wire [7:0] addr_index = haddr[bsb_pkg::IDX_SHIFT +: 8];
  wire upper_clear = (haddr >> (bsb_pkg::IDX_SHIFT + 8)) == '0;
  wire addr_mapped = addr_aligned && upper_clear;
  wire wr_last_bus = wr_pending && wr_index == bsb_pkg::IDX_LAST_BUS;
  wire wr_latency = wr_pending && wr_index == bsb_pkg::IDX_LATENCY;
  wire wr_io_bottom = wr_pending && wr_index == bsb_pkg::IDX_IO_BOTTOM;
  wire wr_io_top = wr_pending && wr_index == bsb_pkg::IDX_IO_TOP;
  wire wr_events = wr_pending && wr_index == bsb_pkg::IDX_EVENTS;

  // Read view of each register
  wire [7:0] io_bottom_view = {io_bottom_nibble,
    bsb_pkg::IO_DECODE_32BIT};
  wire [7:0] io_top_view = {io_top_nibble,
    bsb_pkg::IO_DECODE_32BIT};
  // Fixed bits 9 and 7, and zeros in 10 and 6-0, come from the constant
  wire [15:0] events_view = (event_flags & bsb_pkg::EVENTS_FLAG_MASK) |
    bsb_pkg::EVENTS_FIXED;

  function automatic logic [31:0] read_mux(input logic [7:0] idx);
    logic [31:0] value;
    value = bsb_pkg::RDATA_ZERO;
    case (idx)
      bsb_pkg::IDX_LAST_BUS: value[7:0] = last_downstream_bus_number;
      bsb_pkg::IDX_LATENCY: value[7:0] = downstream_latency_limit;
      bsb_pkg::IDX_IO_BOTTOM: value[7:0] = io_bottom_view;
      bsb_pkg::IDX_IO_TOP: value[7:0] = io_top_view;
      bsb_pkg::IDX_EVENTS: value[15:0] = events_view;
      default: value = bsb_pkg::RDATA_ZERO;
    endcase
    return value;
  endfunction

  // Zero wait states; a write lands before any following read phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_pending ? read_mux(rd_index) : bsb_pkg::RDATA_ZERO;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_pending <= 1'b0;
      rd_pending <= 1'b0;
      wr_index <= 8'h00;
      rd_index <= 8'h00;
    end else if (hready) begin
      wr_pending <= addr_phase && hwrite && addr_mapped;
      rd_pending <= addr_phase && !hwrite && addr_mapped;
      wr_index <= addr_index;
      rd_index <= addr_index;
    end
  end

  // Writable registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      last_downstream_bus_number <= bsb_pkg::LAST_BUS_RESET;
      downstream_latency_limit <= bsb_pkg::LATENCY_RESET;
      io_bottom_nibble <= bsb_pkg::IO_NIBBLE_RESET;
      io_top_nibble <= bsb_pkg::IO_NIBBLE_RESET;
    end else begin
      if (wr_last_bus) begin
        last_downstream_bus_number <= hwdata[7:0];
      end
      if (wr_latency) begin
        downstream_latency_limit <= hwdata[7:0];
      end
      // Low nibble is never stored, so writes there are lost
      if (wr_io_bottom) begin
        io_bottom_nibble <= hwdata[7:4];
      end
      if (wr_io_top) begin
        io_top_nibble <= hwdata[7:4];
      end
    end
  end

  // Event flags: a new event in the clear cycle survives
  wire [15:0] clear_mask = wr_events ?
    (hwdata[15:0] & bsb_pkg::EVENTS_FLAG_MASK) : 16'h0000;
  logic [15:0] set_mask;
  always_comb begin
    set_mask = 16'h0000;
    set_mask[bsb_pkg::EV_PARITY_DETECTED] =
      events.parity_detected;
    set_mask[bsb_pkg::EV_SYSTEM_ERROR] = downstream_system_error;
    set_mask[bsb_pkg::EV_MASTER_ABORT] = events.master_abort;
    set_mask[bsb_pkg::EV_TARGET_ABORT_RX] = events.target_abort_rx;
    set_mask[bsb_pkg::EV_TARGET_ABORT_TX] = events.target_abort_tx;
    set_mask[bsb_pkg::EV_DATA_PARITY] = downstream_parity_error &&
      events.bus_master && parity_response_enable;
  end
  wire [15:0] next_event_flags = ((event_flags & ~clear_mask) | set_mask) &
    bsb_pkg::EVENTS_FLAG_MASK;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      event_flags <= bsb_pkg::EVENTS_RESET & bsb_pkg::EVENTS_FLAG_MASK;
    end else begin
      event_flags <= next_event_flags;
    end
  end

  // The bridge only listens to the system error line
  assign downstream_system_error_out = 1'b0;
  assign downstream_system_error_oe = 1'b0;

  // Configuration forwarding
  wire to_secondary = cfg_req.valid &&
    cfg_req.bus == secondary_bus_number;
  wire behind_bridge = cfg_req.valid &&
    cfg_req.bus >= secondary_bus_number &&
    cfg_req.bus <= last_downstream_bus_number;
  // A request for the primary bus itself is never taken downstream
  wire not_primary = cfg_req.bus != primary_bus_number;
  bsb_pkg::bsb_cfg_route_type next_cfg_route;
  assign next_cfg_route.type0_convert = to_secondary && not_primary;
  assign next_cfg_route.type1_forward = behind_bridge && !to_secondary &&
    not_primary;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg_route <= '0;
    end else begin
      cfg_route <= next_cfg_route;
    end
  end

  // I/O window
  wire [31:0] next_io_base = {io_base_upper, io_bottom_nibble,
    bsb_pkg::IO_LOW_ZEROS};
  wire [31:0] next_io_limit = {io_limit_upper, io_top_nibble,
    bsb_pkg::IO_LOW_ONES};
  wire next_io_hit = io_address >= next_io_base &&
    io_address <= next_io_limit;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      io_window_base <= 32'h0000_0000;
      io_window_limit <= 32'h0000_0000;
      io_window_hit <= 1'b0;
    end else begin
      io_window_base <= next_io_base;
      io_window_limit <= next_io_limit;
      io_window_hit <= next_io_hit;
    end
  end

  // Internal grant and latency counting
  wire next_grant = !other_master_request;
  wire count_expired = latency_active &&
    latency_count >= downstream_latency_limit;
  // Saturating so a long transfer cannot wrap back under the limit
  wire [7:0] next_latency_count = frame_start ? 8'h00 :
    (latency_count == bsb_pkg::LATENCY_MAX) ? latency_count :
    latency_count + 8'h01;
  wire next_active = frame_start || (latency_active && !transfer_done);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      latency_count <= 8'h00;
      latency_active <= 1'b0;
      downstream_grant <= 1'b0;
      latency_terminate <= 1'b0;
    end else begin
      latency_count <= next_latency_count;
      latency_active <= next_active;
      downstream_grant <= next_grant;
      latency_terminate <= count_expired && !next_grant &&
        !transfer_done;
    end
  end

endmodule

// File: bench/bsb_config_regs_sva.sv
// Port assertions for the downstream bus configuration registers
module bsb_config_regs_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Watched ports
  input wire logic [7:0] primary_bus_number,
  input wire logic [7:0] secondary_bus_number,
  input wire logic [15:0] io_base_upper,
  input wire logic [15:0] io_limit_upper,
  input wire bsb_pkg::bsb_cfg_req_type cfg_req,
  input wire bsb_pkg::bsb_cfg_route_type cfg_route,
  input wire logic [31:0] io_window_base,
  input wire logic [31:0] io_window_limit,
  input wire logic transfer_done,
  input wire logic other_master_request,
  input wire logic downstream_grant,
  input wire logic latency_terminate,
  input wire logic downstream_system_error_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_to_sec;
    cfg_req.valid && cfg_req.bus == secondary_bus_number &&
      cfg_req.bus != primary_bus_number;
  endsequence
  sequence s_other_ask;
    other_master_request ##1 other_master_request;
  endsequence
  chk_type0_convert: assert property (
    s_to_sec |=> cfg_route == 2'h1) else $error("no type 0 route");
  chk_no_shallow_fwd: assert property (
    cfg_req.valid && cfg_req.bus <= secondary_bus_number
      |=> !cfg_route.type1_forward) else $error("bad type 1 route");
  chk_idle_route: assert property (
    !cfg_req.valid |=> cfg_route == 2'h0) else $error("route w/o request");
  chk_grant_drop: assert property (
    s_other_ask |-> !downstream_grant) else $error("grant kept");
  chk_term_grant: assert property (
    downstream_grant |-> !latency_terminate) else $error("early end");
  chk_done_ends: assert property (
    transfer_done |=> !latency_terminate) else $error("end after done");
  chk_base_align: assert property (
    1'b1 |=> io_window_base[11:0] == 12'h000 &&
      io_window_base[31:16] == $past(io_base_upper))
    else $error("window bottom wrong");
  chk_limit_ones: assert property (
    1'b1 |=> io_window_limit[11:0] == 12'hfff &&
      io_window_limit[31:16] == $past(io_limit_upper))
    else $error("window top wrong");
  chk_serr_quiet: assert property (
    !downstream_system_error_oe) else $error("system error driven");
endmodule
bind bsb_config_regs bsb_config_regs_sva u_sva (.*);

// File: bench/bsb_far_model.sv
// Far-side agents: competing masters and error sources
module bsb_far_model (
  // Clock, reset and bench commands
  input wire logic clock,
  input wire logic nrst,
  input wire logic want_bus,
  input wire logic [2:0] delay,
  input wire logic [6:0] fault,
  // Downstream lines
  output logic other_master_request,
  output bsb_pkg::bsb_events_type events,
  output logic downstream_system_error,
  output logic downstream_parity_error
);
  logic [2:0] waited;
  // Slow masters take up to eight cycles to arbitrate
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      waited <= 3'h0;
      other_master_request <= 1'b0;
      {events, downstream_system_error, downstream_parity_error} <= 7'h00;
    end else begin
      waited <= want_bus == other_master_request ? 3'h0 : waited + 3'h1;
      if (waited >= delay) other_master_request <= want_bus;
      // Lines copy the fault command one cycle later and stay set while it is held
      {events, downstream_system_error,
        downstream_parity_error} <= fault;
    end
  end
endmodule

// File: bench/bsb_config_regs_tb_top.sv
// Self-checking bench for the downstream bus configuration registers
module bsb_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, nrst = 0, hsel = 0, hwrite = 0, rd_dp = 0, pv = 0;
  logic frame_start = 0, transfer_done = 0, want_bus = 0;
  logic parity_response_enable = 0, hready, hreadyout, hresp;
  logic io_window_hit, downstream_grant, latency_terminate;
  logic other_master_request, downstream_system_error;
  logic downstream_parity_error, downstream_system_error_out;
  logic downstream_system_error_oe;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, delay = 3'h0;
  logic [6:0] fault = 7'h00;
  logic [7:0] primary_bus_number = 8'h00, secondary_bus_number = 8'h05;
  logic [15:0] io_base_upper, io_limit_upper;
  logic [31:0] haddr = 0, hwdata = 0, io_address = 0, hrdata, q[$];
  logic [31:0] io_window_base, io_window_limit;
  logic [15:0] rv[12] = '{16'h0, 16'h0, 16'h1, 16'h1, 16'h280, 16'h0,
    16'h9, 16'h3, 16'h21, 16'h51, 16'h280, 16'h0};
  // Window 2000-5fff: low nibbles written non-zero must not stick
  logic [15:0] wd[6] = '{16'h9, 16'h3, 16'h2f, 16'h5e, 16'hffff, 16'hff};
  logic [7:0] bl[6] = '{8'h5, 8'h6, 8'h9, 8'ha, 8'h4, 8'h0};
  logic [15:0] wo[4] = '{16'h2000, 16'h5fff, 16'h1fff, 16'h6000};
  int n_mismatch = 0, check_count = 0, seed = 20, i, k;
  bsb_pkg::bsb_cfg_req_type cfg_req = 0;
  bsb_pkg::bsb_cfg_route_type cfg_route;
  bsb_pkg::bsb_events_type events;
  bsb_config_regs dut (.*);
  bsb_far_model far (.*);
  assign hready = hreadyout;
  initial forever #25 clock = ~clock;
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (hready !== 1'b1 && i < 20);
    if (hready !== 1'b1) begin
      n_mismatch++;
      stop_test;
    end
  endtask
  // For reads, d carries the expected word
  task automatic bus(input logic w, input int x, input logic [15:0] d);
    @(posedge clock);
    hsel <= 1;
    htrans <= bsb_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= 32'(x) << 2;
    tick;
    {hsel, htrans} <= 3'h0;
    hwdata <= 32'(d);
    rd_dp <= !w;
    if (!w) q.push_back(32'(d));
    tick;
    rd_dp <= 0;
  endtask
  task automatic probe(input logic v, input logic [7:0] b,
    input logic [2:0] r);
    logic [1:0] rt;
    rt = 2'h0;
    if (v && b != primary_bus_number)
      rt = b == secondary_bus_number ? 2'h1 :
        (b > secondary_bus_number && b <= wd[0][7:0]) ? 2'h2 : 2'h0;
    @(posedge clock);
    cfg_req <= {v, b};
    @(posedge clock);
    cfg_req <= 0;
    pv <= 1;
    q.push_back({27'h0, rt, r});
    @(posedge clock);
    pv <= 0;
  endtask
  task automatic pulse(input logic [6:0] f);
    @(posedge clock);
    fault <= f;
    @(posedge clock);
    fault <= 7'h00;
    repeat (3) @(posedge clock);
  endtask
  always @(posedge clock) begin
    if (rd_dp) cmp(q.pop_front(), hrdata);
    if (rd_dp) cmp(32'h0, 32'({hresp, downstream_system_error_out}));
    if (pv) cmp(q.pop_front(), 32'({cfg_route, io_window_hit,
      downstream_grant, latency_terminate}));
  end
  initial begin
    {io_base_upper, io_limit_upper} = {2{16'($random(seed))}};
    repeat (10) @(posedge clock);
    nrst <= 1;
    for (k = 0; k < 6; k++) bus(0, 'h1a + k, rv[k]);
    for (k = 0; k < 6; k++) bus(1, 'h1a + k, wd[k]);
    for (k = 0; k < 6; k++) bus(0, 'h1a + k, rv[k + 6]);
    $display("register access done");
    foreach (bl[m]) probe(1, bl[m], 3'h2);
    foreach (wo[m]) begin
      io_address <= {io_base_upper, wo[m]};
      probe(0, 8'h0, {m < 2, 2'h2});
    end
    $display("routing and window done");
    frame_start <= 1;
    @(posedge clock);
    frame_start <= 0;
    repeat (6) @(posedge clock);
    probe(0, 8'h0, 3'h2);
    delay <= 3'($random(seed));
    want_bus <= 1;
    repeat (16) @(posedge clock);
    probe(0, 8'h0, 3'h1);
    transfer_done <= 1;
    @(posedge clock);
    transfer_done <= 0;
    probe(0, 8'h0, 3'h0);
    want_bus <= 0;
    $display("latency done");
    pulse(7'h7f);
    bus(0, 'h1e, 16'hfa80);
    parity_response_enable <= 1;
    pulse(7'h05);
    bus(0, 'h1e, 16'hfb80);
    bus(1, 'h1e, 16'ha000);
    bus(0, 'h1e, 16'h5b80);
    $display("event flags done");
    stop_test;
  end
endmodule
